//--- sfq_front_end.sv
// Purpose: command front end of a multi-lane serial flash
// Assumes: host uses clock mode 0, clock far slower than clk
// Notes: array, program and erase engines sit outside this block
`timescale 1ns/1ps
`include "sfq_params.svh"
`default_nettype none
// How it works
// - All bytes travel most significant bit first on any lane count.
// - 3Bh dual output read, BBh dual IO read, 92h dual IO identification.
// - 32h quad program, 6Bh quad output read, EBh quad IO read, 94h quad ID.
// - Dual address entry: IO1 odd bits, IO0 even bits, highest pair first.
// - Dual output: bits 7,5,3,1 on IO1, bits 6,4,2,0 on IO0.
// - Quad address entry: IO3 carries bits 23,19,...; others one bit lower.
// - Quad data: IO3..IO0 carry bits 7..4 then 3..0.
// - Quad IO read waits four dummy clocks before data.
// - 77h plus four quad bytes; wrap bits ride IO2..IO0 in one slot.
// - Status and ID reads repeat until select rises.
// - Program takes one data byte or more; index wraps within the page.
// - Security registers at middle byte 10h, 20h, 30h, upper byte 00h.
// - Lone 06h byte sets the write enable latch.
// - Program and erase need the latch set; status write needs it or 50h arming.
// - 50h arms one volatile status write, latch left as it was.
// - Lone 04h clears the latch and the volatile arming.
// - Latch clears at reset and when a write cycle completes.
// - 05h and 35h shift out status bytes on falling edges.
// - Opcodes sampled on rising edges; status read allowed while busy.
// - Writes ending off a byte boundary are ignored.
// - Quad output read only with the quad enable bit set.
module sfq_front_end #(
	parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value
	parameter logic [7:0] DEV_ID = 8'h21 // Arbitrary value
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Flash pins
	input wire logic cs_n_pin,
	input wire logic sck_pin,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe_n,
	// Core status
	input wire logic busy,
	input wire logic [7:0] status1_in,
	input wire logic [7:0] status2_in,
	input wire logic op_complete,
	// Array read
	input wire logic [7:0] rd_data,
	output logic [23:0] mem_addr,
	// Program data stream
	output logic pgm_valid,
	output logic [7:0] pgm_byte,
	output logic [7:0] pgm_index,
	// Accepted commands
	output logic exec_pulse,
	output logic [7:0] exec_op,
	output logic [23:0] exec_addr,
	output logic [9:0] exec_nbytes,
	output logic exec_volatile,
	output logic [1:0] exec_sec_reg,
	// Latches
	output logic write_enable_latch,
	output logic volatile_sr_armed,
	output logic [2:0] wrap_length_bits
);
	// ****************************************
	// Declarations
	// ****************************************
	sfq_lane_if lk();
	sfq_pkg::sfq_state_t st, aft, d_st, d_aft;
	sfq_pkg::sfq_src_t src, d_src;
	sfq_pkg::sfq_lanes_t ln, oln, d_ln, d_oln;
	logic [7:0] op;
	logic op_ok, d_ok, id_pick, qe, bnd;
	logic [31:0] sh, nsh;
	logic [5:0] cnt, ncnt, hb, dum, d_hb, d_dum, step;
	logic [2:0] bitc, wcap;
	logic [3:0] nbc;
	logic [9:0] nbyte;
	logic [7:0] pidx;
	logic [23:0] hdr_addr;
	logic is_prog, is_erase, is_chip;
	logic do_wren, do_wrdi, do_vsr, do_exec;

	function automatic logic [5:0] lane_w(input logic [1:0] c);
		lane_w = 6'h01 << c;
	endfunction

	// Lanes shifted in, earliest bit ends up highest
	function automatic logic [31:0] shift_in(input logic [31:0] s,
		input logic [1:0] c, input logic [3:0] d);
		case (c)
			2'h0: shift_in = {s[30:0], d[0]};
			2'h1: shift_in = {s[29:0], d[1:0]}; // IO1 holds odd bit
			default: shift_in = {s[27:0], d}; // IO3 highest
		endcase
	endfunction

	function automatic logic [1:0] sec_sel(input logic [23:0] a);
		sec_sel = 2'h0;
		if (a[23:16] == `SFQ_SEC_HI) begin
			case (a[15:8])
				`SFQ_SEC_R1: sec_sel = 2'h1;
				`SFQ_SEC_R2: sec_sel = 2'h2;
				`SFQ_SEC_R3: sec_sel = 2'h3;
				default: sec_sel = 2'h0;
			endcase
		end
	endfunction

	// ****************************************
	// Pin sampling and output lanes
	// ****************************************
	sfq_pin_sync u_sync (
		.clk(clk),
		.srst(srst),
		.cs_n_pin(cs_n_pin),
		.sck_pin(sck_pin),
		.io_in(io_in),
		.lk(lk.sync)
	);

	sfq_out_shift u_out (
		.clk(clk),
		.srst(srst),
		.lk(lk.shift)
	);

	assign io_out = lk.io_out;
	assign io_oe_n = lk.io_oe_n;
	assign lk.out_en = (st == sfq_pkg::ST_DOUT) & lk.sel;
	assign lk.out_lanes = oln;
	assign qe = status2_in[`SFQ_QE_POS];

	// Byte offered to the shifter
	always_comb begin
		lk.out_byte = rd_data;
		case (src)
			sfq_pkg::SRC_ST1: begin
				lk.out_byte = status1_in; // Live value, repeats
				lk.out_byte[`SFQ_WEL_POS] = write_enable_latch;
			end
			sfq_pkg::SRC_ST2: lk.out_byte = status2_in;
			sfq_pkg::SRC_ID: lk.out_byte = id_pick ? DEV_ID : MFR_ID;
			default: lk.out_byte = rd_data;
		endcase
	end

	// ****************************************
	// Input shifting and opcode decode
	// ****************************************
	assign step = lane_w(ln);
	assign nsh = shift_in(sh, ln, lk.io_s);
	assign ncnt = cnt + step;
	assign nbc = {1'b0, bitc} + step[3:0];
	// Mode byte is dropped, host keeps it all ones
	assign hdr_addr = (hb == `SFQ_HDR_LONG) ? nsh[31:8] : nsh[23:0];

	// Opcode byte to phase plan; busy lets only status reads in
	always_comb begin
		d_st = sfq_pkg::ST_HDR;
		d_aft = sfq_pkg::ST_SKIP;
		d_ln = 2'h0;
		d_oln = 2'h0;
		d_hb = `SFQ_HDR_SHORT;
		d_dum = 6'h00;
		d_src = sfq_pkg::SRC_MEM;
		d_ok = ~busy;
		case (nsh[7:0])
			`SFQ_OP_RD_ST1, `SFQ_OP_RD_ST2: begin
				d_st = sfq_pkg::ST_DOUT;
				d_ok = 1'b1; // Busy polling
				d_src = (nsh[7:0] == `SFQ_OP_RD_ST1) ? sfq_pkg::SRC_ST1 : sfq_pkg::SRC_ST2;
			end
			`SFQ_OP_READ: d_aft = sfq_pkg::ST_DOUT;
			`SFQ_OP_FREAD, `SFQ_OP_SREAD, `SFQ_OP_DREAD, `SFQ_OP_QREAD: begin
				d_aft = sfq_pkg::ST_DUMMY;
				d_dum = `SFQ_DUMMY_FAST;
				if (nsh[7:0] == `SFQ_OP_DREAD)
					d_oln = 2'h1;
				if (nsh[7:0] == `SFQ_OP_QREAD) begin
					d_oln = 2'h2;
					d_ok = ~busy & qe;
				end
			end
			`SFQ_OP_DIO, `SFQ_OP_DID: begin
				d_ln = 2'h1;
				d_oln = 2'h1;
				d_hb = `SFQ_HDR_LONG;
				d_aft = sfq_pkg::ST_DOUT;
				if (nsh[7:0] == `SFQ_OP_DID)
					d_src = sfq_pkg::SRC_ID;
			end
			`SFQ_OP_QIO, `SFQ_OP_QID: begin
				d_ln = 2'h2;
				d_oln = 2'h2;
				d_hb = `SFQ_HDR_LONG;
				d_aft = sfq_pkg::ST_DUMMY;
				d_dum = `SFQ_DUMMY_QIO;
				if (nsh[7:0] == `SFQ_OP_QID)
					d_src = sfq_pkg::SRC_ID;
				else
					d_ok = ~busy & qe;
			end
			`SFQ_OP_WRAP: begin
				d_st = sfq_pkg::ST_WRAP;
				d_ln = 2'h2;
			end
			`SFQ_OP_PROG, `SFQ_OP_SPROG: d_aft = sfq_pkg::ST_DIN;
			`SFQ_OP_QPROG: begin
				d_aft = sfq_pkg::ST_DIN;
				d_oln = 2'h2;
			end
			`SFQ_OP_ER4K, `SFQ_OP_ER32K, `SFQ_OP_ER64K, `SFQ_OP_SERASE: ;
			default: d_st = sfq_pkg::ST_SKIP;
		endcase
		if (!d_ok)
			d_st = sfq_pkg::ST_SKIP;
	end

	// ****************************************
	// Phase state machine
	// ****************************************
	// Select rising restarts the phase, lanes, counters and shift register
	always_ff @(posedge clk) begin
		if (srst || lk.cs_rise) begin
			st <= sfq_pkg::ST_OPC;
			ln <= 2'h0;
			cnt <= 6'h00;
			bitc <= 3'h0;
			nbyte <= 10'h000;
			sh <= 32'h0;
		end else if (lk.sck_rise) begin
			sh <= nsh; // Sampled on rising edges
			bitc <= nbc[2:0];
			if (nbc[3] && nbyte != 10'h3ff)
				nbyte <= nbyte + 10'h001;
			case (st)
				sfq_pkg::ST_OPC: begin
					if (nbc[3]) begin
						st <= d_st;
						ln <= d_ln;
					end
				end
				sfq_pkg::ST_HDR: begin
					if (ncnt == hb) begin
						st <= aft;
						ln <= oln;
						cnt <= 6'h00;
					end else begin
						cnt <= ncnt;
					end
				end
				sfq_pkg::ST_DUMMY: begin
					if (cnt + 6'h01 == dum)
						st <= sfq_pkg::ST_DOUT; // Dummy clocks done
					else
						cnt <= cnt + 6'h01;
				end
				sfq_pkg::ST_WRAP: begin
					cnt <= ncnt;
					if (ncnt == `SFQ_HDR_LONG)
						st <= sfq_pkg::ST_SKIP;
				end
				default: ;
			endcase
		end
	end

	// Opcode plan held for the rest of the selection
	always_ff @(posedge clk) begin
		if (srst) begin
			op <= 8'h00;
			op_ok <= 1'b0;
			aft <= sfq_pkg::ST_SKIP;
			oln <= 2'h0;
			hb <= `SFQ_HDR_SHORT;
			dum <= 6'h00;
			src <= sfq_pkg::SRC_MEM;
		end else if (lk.sck_rise && st == sfq_pkg::ST_OPC && nbc[3]) begin
			op <= nsh[7:0];
			op_ok <= d_ok;
			aft <= d_aft;
			oln <= d_oln;
			hb <= d_hb;
			dum <= d_dum;
			src <= d_src;
		end
	end

	// ****************************************
	// Address, program stream, wrap setting
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			mem_addr <= 24'h0;
			id_pick <= 1'b0;
		end else if (lk.sck_rise && st == sfq_pkg::ST_HDR && ncnt == hb) begin
			mem_addr <= hdr_addr;
		end else if (lk.cs_rise) begin
			id_pick <= 1'b0;
		end else if (lk.took) begin
			if (src == sfq_pkg::SRC_MEM)
				mem_addr <= mem_addr + 24'h1;
			id_pick <= ~id_pick;
		end
	end

	// Page index wraps, later bytes overwrite earlier
	always_ff @(posedge clk) begin
		if (srst) begin
			pidx <= 8'h00;
			pgm_valid <= 1'b0;
			pgm_byte <= 8'h00;
			pgm_index <= 8'h00;
		end else begin
			pgm_valid <= 1'b0;
			if (lk.sck_rise && st == sfq_pkg::ST_HDR && ncnt == hb) begin
				pidx <= hdr_addr[7:0];
			end else if (lk.sck_rise && st == sfq_pkg::ST_DIN && nbc[3]) begin
				pgm_valid <= 1'b1;
				pgm_byte <= nsh[7:0];
				pgm_index <= pidx;
				pidx <= pidx + 8'h01;
			end
		end
	end

	// Wrap nibble sits in one slot of the four quad bytes
	always_ff @(posedge clk) begin
		if (srst) begin
			wcap <= 3'h0;
			wrap_length_bits <= 3'h0;
		end else if (lk.sck_rise && st == sfq_pkg::ST_WRAP) begin
			if (cnt == `SFQ_WRAP_SLOT)
				wcap <= lk.io_s[2:0];
			if (ncnt == `SFQ_HDR_LONG && op_ok)
				wrap_length_bits <= wcap;
		end
	end

	// ****************************************
	// Command acceptance at select rising
	// ****************************************
	assign bnd = (bitc == 3'h0); // Whole bytes only
	assign is_prog = op == `SFQ_OP_PROG || op == `SFQ_OP_QPROG || op == `SFQ_OP_SPROG;
	assign is_erase = op == `SFQ_OP_ER4K || op == `SFQ_OP_ER32K || op == `SFQ_OP_ER64K
		|| op == `SFQ_OP_SERASE;
	assign is_chip = op == `SFQ_OP_ERCHIP || op == `SFQ_OP_ERCHIP2;
	assign do_wren = lk.cs_rise & op_ok & bnd & nbyte == 10'h001 & op == `SFQ_OP_WR_EN;
	assign do_wrdi = lk.cs_rise & op_ok & bnd & nbyte == 10'h001 & op == `SFQ_OP_WR_DIS;
	assign do_vsr = lk.cs_rise & op_ok & bnd & nbyte == 10'h001 & op == `SFQ_OP_VOL_EN;
	// Latch gates every write kind but an armed volatile status write
	assign do_exec = lk.cs_rise & op_ok & bnd & (
		(is_prog & nbyte >= `SFQ_MIN_PROG & write_enable_latch) |
		(is_erase & nbyte == `SFQ_ERASE_LEN & write_enable_latch) |
		(is_chip & nbyte == 10'h001 & write_enable_latch) |
		(op == `SFQ_OP_WR_ST & (nbyte == 10'h002 | nbyte == 10'h003) &
		(write_enable_latch | volatile_sr_armed)));

	// Set wins over any clear in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			write_enable_latch <= `SFQ_WEL_RST;
			volatile_sr_armed <= 1'b0;
		end else begin
			if (do_wren)
				write_enable_latch <= 1'b1;
			else if (do_wrdi || op_complete)
				write_enable_latch <= 1'b0;
			if (do_vsr)
				volatile_sr_armed <= 1'b1; // Latch untouched
			else if (do_wrdi || (do_exec && op == `SFQ_OP_WR_ST))
				volatile_sr_armed <= 1'b0;
		end
	end

	// Accepted command handed to the core
	always_ff @(posedge clk) begin
		if (srst) begin
			exec_pulse <= 1'b0;
			exec_op <= 8'h00;
			exec_addr <= 24'h0;
			exec_nbytes <= 10'h000;
			exec_volatile <= 1'b0;
			exec_sec_reg <= 2'h0;
		end else begin
			exec_pulse <= do_exec;
			if (do_exec) begin
				exec_op <= op;
				exec_addr <= (op == `SFQ_OP_WR_ST) ? {8'h00, sh[15:0]} : mem_addr;
				exec_nbytes <= nbyte;
				exec_volatile <= (op == `SFQ_OP_WR_ST) & ~write_enable_latch;
				exec_sec_reg <= (op == `SFQ_OP_SPROG || op == `SFQ_OP_SERASE) ?
					sec_sel(mem_addr) : 2'h0;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_wren_sets;
		@(posedge clk) disable iff (srst) do_wren |=> write_enable_latch;
	endproperty
	a_wren_sets: assert property (p_wren_sets) else $error("latch not set");

	property p_wrdi_clears;
		@(posedge clk) disable iff (srst)
		do_wrdi |=> !write_enable_latch && !volatile_sr_armed;
	endproperty
	a_wrdi_clears: assert property (p_wrdi_clears) else $error("not cleared");

	property p_vol_keeps;
		@(posedge clk) disable iff (srst) do_vsr && !op_complete
		|=> volatile_sr_armed && write_enable_latch == $past(write_enable_latch);
	endproperty
	a_vol_keeps: assert property (p_vol_keeps) else $error("volatile arm bad");

	property p_auto_clear;
		@(posedge clk) disable iff (srst) op_complete && !do_wren |=> !write_enable_latch;
	endproperty
	a_auto_clear: assert property (p_auto_clear) else $error("latch kept");

	property p_guarded;
		@(posedge clk) disable iff (srst) exec_pulse && exec_op != `SFQ_OP_WR_ST
		|-> $past(write_enable_latch);
	endproperty
	a_guarded: assert property (p_guarded) else $error("write without latch");

	property p_boundary;
		@(posedge clk) disable iff (srst) exec_pulse |-> $past(bitc) == 3'h0;
	endproperty
	a_boundary: assert property (p_boundary) else $error("partial byte run");

	property p_fresh;
		@(posedge clk) disable iff (srst)
		lk.cs_rise |=> st == sfq_pkg::ST_OPC && nbyte == 10'h000 && bitc == 3'h0;
	endproperty
	a_fresh: assert property (p_fresh) else $error("no restart");

	property p_quiet;
		@(posedge clk) disable iff (srst) !lk.sel |-> io_oe_n == 4'hf;
	endproperty
	a_quiet: assert property (p_quiet) else $error("lane driven");

	property p_qe_gate;
		@(posedge clk) disable iff (srst) lk.sck_rise && !lk.cs_rise && !qe &&
		st == sfq_pkg::ST_OPC && nbc[3] && nsh[7:0] == `SFQ_OP_QREAD
		|=> st == sfq_pkg::ST_SKIP;
	endproperty
	a_qe_gate: assert property (p_qe_gate) else $error("quad read taken");
endmodule
`default_nettype wire

//--- sfq_host_model.sv
// Purpose: host controller model driving select, clock and lanes
// Assumes: clock mode 0, half period of four system clocks
// Notes: clock stands low outside frames; released lanes flip level
`timescale 1ns/1ps
`default_nettype none
module sfq_host_model (
	// Clock
	input wire logic clk,
	// Flash pins
	output logic cs_n_pin,
	output logic sck_pin,
	output logic [3:0] io_in,
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe_n
);
	logic [3:0] drv;
	// Wire level: the device wins on every lane it drives
	assign io_in = (io_out & ~io_oe_n) | (drv & io_oe_n);
	// Idle pins at time zero
	initial begin
		cs_n_pin = 1'h1;
		sck_pin = 1'h0;
		drv = 4'h0;
	end
	// One clock: lanes set while low, sampled just before the next fall
	task automatic tick(input logic [3:0] d, output logic [3:0] q);
		drv = d;
		repeat (4) @(negedge clk);
		sck_pin = 1'h1;
		repeat (4) @(negedge clk);
		q = io_in;
		sck_pin = 1'h0;
	endtask
	// One byte on n lanes, high bits first
	task automatic xbyte(input logic [7:0] b, input int n, output logic [7:0] r);
		logic [3:0] q;
		logic [7:0] s;
		s = b;
		r = 8'h00;
		repeat (8 / n) begin
			case (n)
				1: tick({3'h0, s[7]}, q);
				2: tick({2'h0, s[7:6]}, q);
				default: tick(s[7:4], q);
			endcase
			case (n)
				1: r = {r[6:0], q[1]};
				2: r = {r[5:0], q[1:0]};
				default: r = {r[3:0], q};
			endcase
			s = s << n;
		end
	endtask
	task automatic open_frame();
		cs_n_pin = 1'h0;
		repeat (4) @(negedge clk);
	endtask
	// Select high four system clocks after the last tick, lanes released
	task automatic close_frame();
		repeat (4) @(negedge clk);
		cs_n_pin = 1'h1;
		drv = ~drv;
		repeat (8) @(negedge clk);
	endtask
	// Opcode on one lane, then three address bytes on n lanes
	task automatic hdr(input logic [7:0] op, input logic [23:0] a, input int n);
		logic [7:0] r;
		open_frame();
		xbyte(op, 1, r);
		for (int i = 2; i >= 0; i--) xbyte(a[i*8 +: 8], n, r);
	endtask
endmodule
`default_nettype wire

//--- sfq_lane_if.sv
// Purpose: carrier between pin sampler, output shifter and core
// Assumes: all signals on the one system clock
// Notes: events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface sfq_lane_if;
	// Sampled pin side
	logic sel;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	logic [3:0] io_s;
	// Output shifter side
	logic out_en;
	sfq_pkg::sfq_lanes_t out_lanes;
	logic [7:0] out_byte;
	logic took;
	logic [3:0] io_out;
	logic [3:0] io_oe_n;
	modport sync (output sel, cs_rise, sck_rise, sck_fall, io_s);
	modport shift (input sck_fall, out_en, out_lanes, out_byte,
		output took, io_out, io_oe_n);
	modport core (input sel, cs_rise, sck_rise, sck_fall, io_s, took, io_out,
		io_oe_n, output out_en, out_lanes, out_byte);
endinterface
`default_nettype wire

//--- sfq_out_shift.sv
// Purpose: drives output bytes onto one, two or four lanes
// Assumes: next byte is stable before each falling clock edge
// Notes: lanes float until the first falling edge of an output phase
`timescale 1ns/1ps
`default_nettype none
module sfq_out_shift (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Core side
	sfq_lane_if.shift lk
);
	logic [7:0] sh;
	logic [3:0] left;
	logic drv;
	logic [3:0] step;

	// Top bits of a byte placed on the lanes, most significant first
	function automatic logic [3:0] chunk(input logic [7:0] b, input logic [1:0] c);
		case (c)
			2'h0: chunk = {2'h0, b[7], 1'b0}; // Single lane is IO1
			2'h1: chunk = {2'h0, b[7:6]}; // Odd bit on IO1
			default: chunk = b[7:4]; // High nibble first
		endcase
	endfunction

	function automatic logic [3:0] lane_mask(input logic [1:0] c);
		case (c)
			2'h0: lane_mask = 4'h2;
			2'h1: lane_mask = 4'h3;
			default: lane_mask = 4'hf;
		endcase
	endfunction

	assign step = 4'h1 << lk.out_lanes;
	// Byte is taken on the falling edge that finds the shifter empty
	assign lk.took = lk.out_en & lk.sck_fall & (left == 4'h0);
	// Drive only inside an output phase
	assign lk.io_oe_n = ~(lane_mask(lk.out_lanes) & {4{drv & lk.out_en}});

	// Change outputs on falling clock edges
	always_ff @(posedge clk) begin
		if (srst || !lk.out_en) begin
			left <= 4'h0;
			drv <= 1'b0;
			sh <= 8'h00;
			lk.io_out <= 4'h0;
		end else if (lk.sck_fall) begin
			drv <= 1'b1;
			if (left == 4'h0) begin
				lk.io_out <= chunk(lk.out_byte, lk.out_lanes);
				sh <= lk.out_byte << step;
				left <= 4'h8 - step;
			end else begin
				lk.io_out <= chunk(sh, lk.out_lanes);
				sh <= sh << step;
				left <= left - step;
			end
		end
	end
endmodule
`default_nettype wire

//--- sfq_params.svh
// Purpose: constants of the serial flash command front end
// Assumes: included by bare name wherever they are needed
// Notes: opcodes, field positions, phase lengths, reset values
`ifndef SFQ_PARAMS_SVH
`define SFQ_PARAMS_SVH
// ****************************************
// Opcodes
// ****************************************
`define SFQ_OP_WR_EN 8'h06
`define SFQ_OP_WR_DIS 8'h04
`define SFQ_OP_VOL_EN 8'h50
`define SFQ_OP_RD_ST1 8'h05
`define SFQ_OP_RD_ST2 8'h35
`define SFQ_OP_WR_ST 8'h01
`define SFQ_OP_PROG 8'h02
`define SFQ_OP_QPROG 8'h32
`define SFQ_OP_SPROG 8'h42
`define SFQ_OP_SERASE 8'h44
`define SFQ_OP_SREAD 8'h48
`define SFQ_OP_ER4K 8'h20
`define SFQ_OP_ER32K 8'h52
`define SFQ_OP_ER64K 8'hd8
`define SFQ_OP_ERCHIP 8'hc7
`define SFQ_OP_ERCHIP2 8'h60
`define SFQ_OP_READ 8'h03
`define SFQ_OP_FREAD 8'h0b
`define SFQ_OP_DREAD 8'h3b
`define SFQ_OP_DIO 8'hbb
`define SFQ_OP_DID 8'h92
`define SFQ_OP_QREAD 8'h6b
`define SFQ_OP_QIO 8'heb
`define SFQ_OP_QID 8'h94
`define SFQ_OP_WRAP 8'h77
// ****************************************
// Phase lengths, fields, reset values
// ****************************************
`define SFQ_HDR_SHORT 6'h18
`define SFQ_HDR_LONG 6'h20
`define SFQ_DUMMY_FAST 6'h08
`define SFQ_DUMMY_QIO 6'h04
`define SFQ_WRAP_SLOT 6'h18
`define SFQ_WEL_POS 1
`define SFQ_QE_POS 1
`define SFQ_SEC_HI 8'h00
`define SFQ_SEC_R1 8'h10
`define SFQ_SEC_R2 8'h20
`define SFQ_SEC_R3 8'h30
`define SFQ_MIN_PROG 10'h005
`define SFQ_ERASE_LEN 10'h004
`define SFQ_WEL_RST 1'b0
`endif

//--- sfq_pin_sync.sv
// Purpose: two-stage sampling of select, clock and lanes, edge events
// Assumes: serial clock far slower than the system clock
// Notes: lanes and clock share one latency, so setup is kept
`timescale 1ns/1ps
`default_nettype none
module sfq_pin_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Raw pins
	input wire logic cs_n_pin,
	input wire logic sck_pin,
	input wire logic [3:0] io_in,
	// Sampled events
	sfq_lane_if.sync lk
);
	logic [5:0] meta;
	logic [5:0] stab;
	logic prev_cs_n;
	logic prev_sck;

	// Synchroniser; only the second stage is looked at
	always_ff @(posedge clk) begin
		if (srst) begin
			meta <= 6'h20;
			stab <= 6'h20;
			prev_cs_n <= 1'b1;
			prev_sck <= 1'b0;
		end else begin
			meta <= {cs_n_pin, sck_pin, io_in};
			stab <= meta;
			prev_cs_n <= stab[5];
			prev_sck <= stab[4];
		end
	end

	// Edge events, clock edges only count while selected
	assign lk.sel = ~stab[5];
	assign lk.cs_rise = stab[5] & ~prev_cs_n;
	assign lk.sck_rise = stab[4] & ~prev_sck & ~stab[5];
	assign lk.sck_fall = ~stab[4] & prev_sck & ~stab[5];
	assign lk.io_s = stab[3:0];
endmodule
`default_nettype wire

//--- sfq_pkg.sv
// Purpose: types shared by the flash front end modules
// Assumes: nothing
// Notes: lane codes are log2 of the lane count
`default_nettype none
package sfq_pkg;
	typedef enum logic [6:0] {
		ST_OPC = 7'h01, ST_HDR = 7'h02, ST_DUMMY = 7'h04, ST_DIN = 7'h08,
		ST_DOUT = 7'h10, ST_WRAP = 7'h20, ST_SKIP = 7'h40
	} sfq_state_t;
	typedef enum logic [1:0] {
		SRC_ST1 = 2'h0, SRC_ST2 = 2'h1, SRC_ID = 2'h2, SRC_MEM = 2'h3
	} sfq_src_t;
	typedef logic [1:0] sfq_lanes_t;
endpackage
`default_nettype wire

//--- test_serial_flash_multi_io_command_front_end.sv
// Purpose: self-checking bench for the flash command front end
// Assumes: host model drives the pins, core inputs driven here
// Notes: expectations built from opcodes and lane tables
`timescale 1ns/1ps
`include "sfq_params.svh"
`default_nettype none
module test_serial_flash_multi_io_command_front_end;
	logic clk, srst, busy, op_complete, cs_n_pin, sck_pin;
	logic [7:0] status1_in, status2_in, rd_data, pgm_byte, pgm_index, exec_op, r;
	logic [3:0] io_in, io_out, io_oe_n, q;
	logic [23:0] mem_addr, exec_addr;
	logic [23:0] n_exec = 24'h0;
	logic [23:0] n_pgm = 24'h0;
	logic [9:0] exec_nbytes;
	logic [1:0] exec_sec_reg;
	logic [2:0] wrap_length_bits;
	logic pgm_valid, exec_pulse, exec_volatile, write_enable_latch, volatile_sr_armed;
	int n_fail, comparisons;
	sfq_front_end u_sfq_front_end (.clk, .srst, .cs_n_pin, .sck_pin, .io_in, .io_out,
		.io_oe_n, .busy, .status1_in, .status2_in, .op_complete, .rd_data, .mem_addr,
		.pgm_valid, .pgm_byte, .pgm_index, .exec_pulse, .exec_op, .exec_addr, .exec_nbytes,
		.exec_volatile, .exec_sec_reg, .write_enable_latch, .volatile_sr_armed,
		.wrap_length_bits);
	sfq_host_model u_sfq_host_model (.clk, .cs_n_pin, .sck_pin, .io_in, .io_out, .io_oe_n);
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	// Accepted commands are pulses, so count them
	always @(posedge clk) begin
		if (exec_pulse === 1'h1) n_exec <= n_exec + 24'h1;
		if (pgm_valid === 1'h1) n_pgm <= n_pgm + 24'h1;
	end
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] op);
		u_sfq_host_model.open_frame();
		u_sfq_host_model.xbyte(op, 1, r);
		u_sfq_host_model.close_frame();
	endtask
	// Two bytes read: the second must repeat the first
	task automatic rd_status(input logic [7:0] op, input logic [7:0] e);
		u_sfq_host_model.open_frame();
		u_sfq_host_model.xbyte(op, 1, r);
		repeat (2) begin
			u_sfq_host_model.xbyte(8'h00, 1, r);
			chk(r, e);
		end
		chk(io_oe_n[1], 1'h0);
		u_sfq_host_model.close_frame();
		chk(io_oe_n, 4'hf);
	endtask
	// Single-lane header, eight dummy clocks, one byte on n lanes
	task automatic rd(input logic [7:0] op, input int n);
		u_sfq_host_model.hdr(op, 24'h000100, 1);
		repeat (8) u_sfq_host_model.tick(4'h0, q);
		u_sfq_host_model.xbyte(8'h00, n, r);
	endtask
	initial begin
		srst = 1'h1;
		busy = 1'h0;
		op_complete = 1'h0;
		status1_in = 8'ha4;
		status2_in = 8'h02;
		rd_data = 8'h96;
		repeat (16) @(negedge clk);
		srst = 1'h0;
		chk(io_oe_n, 4'hf);
		chk(write_enable_latch, 1'h0);
		cmd(`SFQ_OP_WR_EN);
		chk(write_enable_latch, 1'h1);
		cmd(`SFQ_OP_WR_DIS);
		chk(write_enable_latch, 1'h0);
		cmd(`SFQ_OP_VOL_EN);
		chk({volatile_sr_armed, write_enable_latch}, 2'h2);
		cmd(`SFQ_OP_WR_DIS);
		chk(volatile_sr_armed, 1'h0);
		// Status polled while busy; write enable ignored meanwhile
		busy = 1'h1;
		cmd(`SFQ_OP_WR_EN);
		chk(write_enable_latch, 1'h0);
		rd_status(`SFQ_OP_RD_ST1, 8'ha4);
		busy = 1'h0;
		cmd(`SFQ_OP_WR_EN);
		rd_status(`SFQ_OP_RD_ST1, 8'ha6);
		rd_status(`SFQ_OP_RD_ST2, 8'h02);
		// Cut short inside a data byte
		u_sfq_host_model.hdr(`SFQ_OP_PROG, 24'h001005, 1);
		repeat (3) u_sfq_host_model.tick(4'h1, q);
		u_sfq_host_model.close_frame();
		chk(n_exec, 24'h0);
		// One byte past a full page: index wraps to the start
		u_sfq_host_model.hdr(`SFQ_OP_PROG, 24'h003000, 1);
		for (int k = 0; k < 257; k++) u_sfq_host_model.xbyte(k[7:0] ^ 8'h5a, 1, r);
		u_sfq_host_model.close_frame();
		chk(n_exec, 24'h1);
		chk({exec_op, exec_nbytes}, {8'h02, 10'h105});
		chk(exec_addr, 24'h003000);
		chk({pgm_byte, pgm_index}, 16'h5a00);
		chk(n_pgm, 24'h000101);
		@(negedge clk) op_complete = 1'h1;
		@(negedge clk) op_complete = 1'h0;
		chk(write_enable_latch, 1'h0);
		// Security program refused without the latch, then accepted
		for (int i = 0; i < 2; i++) begin
			if (i == 1) cmd(`SFQ_OP_WR_EN);
			u_sfq_host_model.hdr(`SFQ_OP_SPROG, 24'h002007, 1);
			u_sfq_host_model.xbyte(8'h11, 1, r);
			u_sfq_host_model.close_frame();
			chk(n_exec, 24'h1 + i[23:0]);
		end
		chk(exec_sec_reg, 2'h2);
		// Quad address, mode byte of ones, four dummy clocks, data
		u_sfq_host_model.hdr(`SFQ_OP_QIO, 24'h012345, 4);
		u_sfq_host_model.xbyte(8'hff, 4, r);
		repeat (4) u_sfq_host_model.tick(4'h0, q);
		u_sfq_host_model.xbyte(8'h00, 4, r);
		chk(r, 8'h96);
		chk(mem_addr[23:8], 16'h0123);
		u_sfq_host_model.close_frame();
		status2_in = 8'h00;
		rd(`SFQ_OP_DREAD, 2);
		chk(r, 8'h96);
		u_sfq_host_model.close_frame();
		// Dual address entry, no dummy clocks before data
		u_sfq_host_model.hdr(`SFQ_OP_DIO, 24'h00a5c3, 2);
		u_sfq_host_model.xbyte(8'hff, 2, r);
		u_sfq_host_model.xbyte(8'h00, 2, r);
		chk({mem_addr[23:8], r}, 24'h00a596);
		u_sfq_host_model.close_frame();
		rd(`SFQ_OP_QREAD, 4);
		chk(io_oe_n, 4'hf);
		u_sfq_host_model.close_frame();
		// Only the seventh quad slot carries the wrap bits
		u_sfq_host_model.open_frame();
		u_sfq_host_model.xbyte(`SFQ_OP_WRAP, 1, r);
		for (int i = 0; i < 8; i++) u_sfq_host_model.tick(i == 6 ? 4'h5 : 4'ha, q);
		u_sfq_host_model.close_frame();
		chk(wrap_length_bits, 3'h5);
		// Mid-run reset drops latch and settings
		@(negedge clk) srst = 1'h1;
		repeat (4) @(negedge clk);
		srst = 1'h0;
		chk({write_enable_latch, wrap_length_bits, exec_sec_reg}, 6'h00);
		// Quad program of one byte
		cmd(`SFQ_OP_WR_EN);
		u_sfq_host_model.hdr(`SFQ_OP_QPROG, 24'h000010, 1);
		u_sfq_host_model.xbyte(8'hc3, 4, r);
		u_sfq_host_model.close_frame();
		chk({exec_op, pgm_byte, pgm_index}, 24'h32c310);
		// Volatile status write with the latch clear
		cmd(`SFQ_OP_WR_DIS);
		cmd(`SFQ_OP_VOL_EN);
		u_sfq_host_model.open_frame();
		u_sfq_host_model.xbyte(`SFQ_OP_WR_ST, 1, r);
		u_sfq_host_model.xbyte(8'h3c, 1, r);
		u_sfq_host_model.close_frame();
		chk({n_exec[3:0], exec_op, exec_volatile, volatile_sr_armed, exec_addr[7:0]},
			{4'h4, 8'h01, 2'h2, 8'h3c});
		close_out();
	end
	// Watchdog: the run needs near 21k clocks, allow 50k
	initial begin
		#2500000;
		n_fail++;
		close_out();
	end
endmodule
`default_nettype wire
